// >>> hw/hold_timer.sv
// Hold timer: counts while a level stands, restarts when it drops
`timescale 1ns/1ps
module hold_timer #(
  parameter int W = 31
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Control
  input  wire logic         active,
  input  wire logic [W-1:0] limit,
  output logic              done
);
  logic [W-1:0] count;

  // ==========================================================================
  // Counter saturates so one long hold yields one completion only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      done  <= 1'b0;
    end else if (!active) begin
      count <= '0;
      done  <= 1'b0;
    end else if (count < limit) begin
      count <= count + W'(1);
      done  <= (count + W'(1)) >= limit;
    end else begin
      done  <= 1'b1;
    end
  end
endmodule

// >>> hw/push_button_reset_delay.sv
// Delayed push-button reset supervisor top level
`timescale 1ns/1ps

module push_button_reset_delay import reset_delay_pkg::*; #(
  parameter logic [1:0]      VARIANT        = VARIANT_COMBINED,
  parameter logic            ACTIVE_HIGH    = 1'b0,
  parameter logic            POWER_ON_RESET = 1'b1,
  parameter logic            SUPPLY_MONITOR = 1'b1,
  parameter longint unsigned SHORT_CYCLES   = SETUP_SHORT_CYCLES,
  parameter longint unsigned MID_CYCLES     = SETUP_MID_CYCLES,
  parameter longint unsigned LONG_CYCLES    = SETUP_LONG_CYCLES,
  parameter longint unsigned PULSE_LEN      = PULSE_CYCLES,
  parameter longint unsigned SETTLE_LEN     = SETTLE_CYCLES
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Buttons and selector
  input  wire logic       primary_button_n,
  input  wire logic       secondary_button_n,
  input  wire logic       instant_reset_in,
  input  wire logic [1:0] delay_select_tristate,
  // Comparators
  input  wire logic       supply_low,
  input  wire logic       battery_low,
  // Outputs
  output logic            reset_out,
  output logic            battery_low_n
);

  localparam int CW = 31;

  function automatic logic [CW-1:0] setup_limit(input logic [1:0] sel);
    case (sel)
      SEL_SHORT: setup_limit = CW'(SHORT_CYCLES);
      SEL_LONG:  setup_limit = CW'(LONG_CYCLES);
      default:   setup_limit = CW'(MID_CYCLES);
    endcase
  endfunction

  // ==========================================================================
  // Input synchronisers
  logic       prim_n_s;
  logic       sec_n_s;
  logic       inst_s;
  logic       vlow_s;
  logic       blow_s;
  logic [1:0] sel_s;

  sync_two_ff #(.RESET_LEVEL(1'b1)) u_prim (
    .clock(clock), .rst_n(rst_n), .async_in(primary_button_n), .sync_out(prim_n_s));
  sync_two_ff #(.RESET_LEVEL(1'b1)) u_sec (
    .clock(clock), .rst_n(rst_n), .async_in(secondary_button_n), .sync_out(sec_n_s));
  sync_two_ff #(.RESET_LEVEL(1'b0)) u_inst (
    .clock(clock), .rst_n(rst_n), .async_in(instant_reset_in), .sync_out(inst_s));
  sync_two_ff #(.RESET_LEVEL(1'b0)) u_vlow (
    .clock(clock), .rst_n(rst_n), .async_in(supply_low), .sync_out(vlow_s));
  sync_two_ff #(.RESET_LEVEL(1'b0)) u_blow (
    .clock(clock), .rst_n(rst_n), .async_in(battery_low), .sync_out(blow_s));
  sync_two_ff #(.RESET_LEVEL(1'b0)) u_sel0 (
    .clock(clock), .rst_n(rst_n), .async_in(delay_select_tristate[0]), .sync_out(sel_s[0]));
  sync_two_ff #(.RESET_LEVEL(1'b0)) u_sel1 (
    .clock(clock), .rst_n(rst_n), .async_in(delay_select_tristate[1]), .sync_out(sel_s[1]));

  // ==========================================================================
  // Setup delay measurement
  logic          buttons_held;
  logic          setup_done;
  logic          setup_done_q;
  logic          setup_fire;
  logic [CW-1:0] limit;

  // The selector is a strap; sampling it live keeps a mis-strap recoverable
  assign limit = setup_limit(sel_s);
  // Independent variant ignores the second button entirely
  assign buttons_held = (VARIANT == VARIANT_INDEPENDENT) ? !prim_n_s
                                                        : (!prim_n_s && !sec_n_s);

  hold_timer #(.W(CW)) u_setup (
    .clock(clock), .rst_n(rst_n), .active(buttons_held), .limit(limit),
    .done(setup_done));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      setup_done_q <= 1'b0;
    end else begin
      setup_done_q <= setup_done;
    end
  end

  // One pulse per long hold, however long the hold continues
  assign setup_fire = setup_done && !setup_done_q;

  // ==========================================================================
  // Instant input: edge trigger with release settle
  pulse_state_t  state;
  logic          inst_q;
  logic          inst_armed;
  logic          inst_fire;
  logic [CW-1:0] settle_count;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      inst_q <= 1'b0;
    end else begin
      inst_q <= inst_s;
    end
  end

  assign inst_fire = (VARIANT == VARIANT_INDEPENDENT) && inst_armed
                     && inst_s && !inst_q;

  // Rearm only after the input has stayed low for the settle time
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      inst_armed   <= 1'b1;
      settle_count <= '0;
    end else if (inst_fire) begin
      inst_armed   <= 1'b0;
      settle_count <= '0;
    end else if (!inst_armed) begin
      if (inst_s || state != ST_IDLE) begin
        settle_count <= '0;
      end else if (settle_count + CW'(1) >= CW'(SETTLE_LEN)) begin
        inst_armed   <= 1'b1;
        settle_count <= '0;
      end else begin
        settle_count <= settle_count + CW'(1);
      end
    end
  end

  // ==========================================================================
  // Reset pulse generator
  logic [CW-1:0] pulse_count;
  logic          undervolt;
  logic          trigger;

  assign undervolt = SUPPLY_MONITOR && vlow_s;
  assign trigger   = setup_fire || inst_fire;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state       <= POWER_ON_RESET ? ST_PULSE : ST_IDLE;
      pulse_count <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          pulse_count <= '0;
          if (undervolt) begin
            state <= ST_HOLD;
          end else if (trigger) begin
            state <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (undervolt) begin
            state       <= ST_HOLD;
            pulse_count <= '0;
          end else if (pulse_count + CW'(1) >= CW'(PULSE_LEN)) begin
            state       <= ST_IDLE;
            pulse_count <= '0;
          end else begin
            pulse_count <= pulse_count + CW'(1);
          end
        end
        ST_HOLD: begin
          pulse_count <= '0;
          if (!undervolt) begin
            state <= ST_PULSE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Output registers
  logic next_reset_active;

  assign next_reset_active = (state != ST_IDLE) || undervolt;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reset_out <= ACTIVE_HIGH ? POWER_ON_RESET : !POWER_ON_RESET;
    end else begin
      reset_out <= ACTIVE_HIGH ? next_reset_active : !next_reset_active;
    end
  end

  // Battery flag never feeds the reset path
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      battery_low_n <= 1'b1;
    end else begin
      battery_low_n <= (VARIANT == VARIANT_BATTERY) ? !blow_s : 1'b1;
    end
  end

  // ==========================================================================
  // Assertions
  logic          reset_active;
  logic [CW-1:0] held_run;

  assign reset_active = ACTIVE_HIGH ? reset_out : !reset_out;

  // Held run counted apart from the timer, so a timer fault cannot hide itself
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      held_run <= '0;
    end else if (!buttons_held) begin
      held_run <= '0;
    end else if (held_run != '1) begin
      held_run <= held_run + CW'(1);
    end
  end

  a_short_press_ignored: assert property (@(posedge clock) disable iff (!rst_n)
    (!buttons_held && !undervolt && state == ST_IDLE && !inst_fire) |=> !setup_fire)
    else $error("setup completion without a held button");

  a_no_early_fire: assert property (@(posedge clock) disable iff (!rst_n)
    setup_fire |-> held_run >= limit)
    else $error("setup completed before the delay ran out");

  a_setup_starts_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    (setup_fire && state == ST_IDLE && !undervolt) |=> state == ST_PULSE ##1 reset_active)
    else $error("setup completion did not start a reset pulse");

  a_trigger_starts: assert property (@(posedge clock) disable iff (!rst_n)
    (trigger && state == ST_IDLE && !undervolt) |=> state == ST_PULSE)
    else $error("trigger in idle did not start a pulse");

  a_pulse_bounded: assert property (@(posedge clock) disable iff (!rst_n)
    state == ST_PULSE |-> pulse_count < CW'(PULSE_LEN))
    else $error("reset pulse counter ran past its length");

  a_pulse_release: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ST_PULSE && !undervolt && pulse_count == CW'(PULSE_LEN - 1)) |=> state == ST_IDLE)
    else $error("reset pulse not released at its length");

  a_undervolt_asserts: assert property (@(posedge clock) disable iff (!rst_n)
    undervolt |=> reset_active)
    else $error("reset not asserted under undervoltage");

  a_hold_stays: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ST_HOLD && undervolt) |=> state == ST_HOLD)
    else $error("undervoltage hold left too early");

  a_recovery_holds: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ST_HOLD && !undervolt) |=> state == ST_PULSE && pulse_count == '0)
    else $error("recovery did not start the timeout");

  a_single_fire: assert property (@(posedge clock) disable iff (!rst_n)
    setup_fire |=> !setup_fire)
    else $error("setup completion repeated");

  a_pair_needed: assert property (@(posedge clock) disable iff (!rst_n)
    (VARIANT != VARIANT_INDEPENDENT && sec_n_s) |-> !buttons_held)
    else $error("single button treated as held pair");

  a_instant_ignored: assert property (@(posedge clock) disable iff (!rst_n)
    (VARIANT != VARIANT_INDEPENDENT) |-> !inst_fire)
    else $error("instant input fired outside its variant");

  a_instant_disarm: assert property (@(posedge clock) disable iff (!rst_n)
    inst_fire |=> !inst_armed ##1 state != ST_IDLE || reset_active)
    else $error("instant trigger did not disarm");

  a_battery_follow: assert property (@(posedge clock) disable iff (!rst_n)
    (VARIANT == VARIANT_BATTERY) |=> battery_low_n == !$past(blow_s))
    else $error("battery flag does not follow comparator");

  a_flag_apart: assert property (@(posedge clock) disable iff (!rst_n)
    ($changed(blow_s) && state == ST_IDLE && !undervolt && !trigger) |=> !reset_active)
    else $error("battery change disturbed the reset output");

  // Scenarios worth seeing in simulation
  c_setup_reset:   cover property (@(posedge clock) disable iff (!rst_n) setup_fire);
  c_instant_reset: cover property (@(posedge clock) disable iff (!rst_n) inst_fire);
  c_undervolt:     cover property (@(posedge clock) disable iff (!rst_n)
    state == ST_HOLD ##1 state == ST_PULSE);
  c_short_press:   cover property (@(posedge clock) disable iff (!rst_n)
    buttons_held ##1 !buttons_held && !setup_done_q);
  c_battery_low:   cover property (@(posedge clock) disable iff (!rst_n) !battery_low_n);

endmodule

// >>> hw/reset_delay_pkg.sv
// Shared constants for the push-button reset delay supervisor
package reset_delay_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLOCK_HZ             = 125_000_000;
  localparam int unsigned SETUP_SHORT_S        = 2;
  localparam int unsigned SETUP_MID_S          = 6;
  localparam int unsigned SETUP_LONG_S         = 10;
  localparam int unsigned SETTLE_MS            = 240;
  localparam int unsigned PULSE_MS             = 140;
  localparam longint unsigned SETUP_SHORT_CYCLES = longint'(SETUP_SHORT_S) * CLOCK_HZ;
  localparam longint unsigned SETUP_MID_CYCLES   = longint'(SETUP_MID_S) * CLOCK_HZ;
  localparam longint unsigned SETUP_LONG_CYCLES  = longint'(SETUP_LONG_S) * CLOCK_HZ;
  localparam longint unsigned SETTLE_CYCLES      = (longint'(SETTLE_MS) * CLOCK_HZ + 999) / 1000;
  localparam longint unsigned PULSE_CYCLES       = (longint'(PULSE_MS) * CLOCK_HZ + 999) / 1000;

  // ==========================================================================
  // Delay selection codes
  localparam logic [1:0] SEL_SHORT = 2'h0;
  localparam logic [1:0] SEL_MID   = 2'h1;
  localparam logic [1:0] SEL_LONG  = 2'h2;

  // ==========================================================================
  // Variants and reset values
  localparam logic [1:0] VARIANT_COMBINED    = 2'h0;
  localparam logic [1:0] VARIANT_INDEPENDENT = 2'h1;
  localparam logic [1:0] VARIANT_BATTERY     = 2'h2;
  localparam logic [1:0] SYNC_RESET_VALUE    = 2'h0;

  typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_HOLD} pulse_state_t;

endpackage

// >>> hw/sync_two_ff.sv
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module sync_two_ff #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Level
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= RESET_LEVEL;
      sync_out <= RESET_LEVEL;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// >>> tb/push_button_reset_delay_tb.sv
// Self-checking bench for the push-button reset supervisor
`timescale 1ns/1ps
module push_button_reset_delay_tb;
  import reset_delay_pkg::*;
  localparam int PL = 10;
  logic        clock = 1'h0;
  logic        rst_n = 1'h0;
  logic        primary_button_n = 1'h1;
  logic        secondary_button_n = 1'h1;
  logic        instant_reset_in = 1'h0;
  logic [1:0]  delay_select_tristate = 2'h0;
  logic        supply_low = 1'h0;
  logic        battery_low = 1'h0;
  logic        reset_out;
  logic        battery_low_n;
  logic        pulse_done;
  logic [31:0] pulse_len;
  logic [31:0] rnd = 32'hB57B;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          q_lo[$];
  int          q_sl[$];
  int          lim[4] = '{20, 40, 60, 40};

  always #4 clock = ~clock;

  push_button_reset_delay #(.VARIANT(VARIANT_BATTERY), .SHORT_CYCLES(20), .MID_CYCLES(40),
    .LONG_CYCLES(60), .PULSE_LEN(PL)) u_push_button_reset_delay (
    .clock(clock), .rst_n(rst_n), .primary_button_n(primary_button_n),
    .secondary_button_n(secondary_button_n), .instant_reset_in(instant_reset_in),
    .delay_select_tristate(delay_select_tristate), .supply_low(supply_low),
    .battery_low(battery_low), .reset_out(reset_out), .battery_low_n(battery_low_n));

  reset_receiver u_reset_receiver (.clock(clock), .rst_n(rst_n), .reset_out(reset_out),
    .pulse_done(pulse_done), .pulse_len(pulse_len));

  // ==========================================================================
  // Checking and closing
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Counts: %0d compared, %0d mismatches", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Oldest note is matched against every measured pulse
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      check("timeout", 32'h1, 32'h0);
      give_verdict();
    end
    if (pulse_done) begin
      if (q_lo.size() == 0) begin
        check("unexpected pulse", pulse_len, 32'h0);
      end else begin
        int lo;
        int sl;
        lo = q_lo.pop_front();
        sl = q_sl.pop_front();
        check("pulse length ok", 32'(pulse_len >= lo && pulse_len <= lo + sl), 32'h1);
      end
    end
  end

  // ==========================================================================
  // Stimulus
  task automatic hold(input logic p, input logic s, input int n, input int gap);
    @(posedge clock);
    primary_button_n <= p;
    secondary_button_n <= s;
    repeat (n) @(posedge clock);
    primary_button_n <= 1'h1;
    secondary_button_n <= 1'h1;
    repeat (gap) @(posedge clock);
  endtask

  initial begin
    repeat (10) @(posedge clock);
    check("reset during rst_n", reset_out, 1'h0);
    repeat (6) @(posedge clock);
    rst_n <= 1'h1;
    repeat (PL + 12) @(posedge clock);
    check("reset released", reset_out, 1'h1);
    $display("Done: power-on reset");
    // Two short presses with a two-cycle release: counter must restart
    hold(1'h0, 1'h0, 17, 1);
    hold(1'h0, 1'h0, 17, 30);
    $display("Done: short presses");
    // One button alone never starts a reset in the battery variant
    hold(1'h0, 1'h1, 70, 30);
    hold(1'h1, 1'h0, 70, 30);
    $display("Done: single button");
    // Each selector code, held three setups long, gives one pulse only
    for (int i = 0; i < 4; i++) begin
      delay_select_tristate <= 2'(i);
      repeat (4) @(posedge clock);
      hold(1'h0, 1'h0, lim[i] - 3, PL + 20);
      q_lo.push_back(PL);
      q_sl.push_back(0);
      hold(1'h0, 1'h0, 3 * lim[i], PL + 20);
    end
    $display("Done: setup delays");
    // Undervoltage holds reset, then the timeout runs after recovery
    q_lo.push_back(29 + PL);
    q_sl.push_back(3);
    supply_low <= 1'h1;
    repeat (30) @(posedge clock);
    supply_low <= 1'h0;
    repeat (PL + 20) @(posedge clock);
    $display("Done: undervoltage");
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr_next(rnd);
      battery_low <= rnd[0];
      instant_reset_in <= rnd[1];
      repeat (6) @(posedge clock);
      check("battery flag", battery_low_n, {31'h0, ~rnd[0]});
      check("reset idle", reset_out, 1'h1);
    end
    $display("Done: battery flag");
    check("pending pulses", 32'(q_lo.size()), 32'h0);
    give_verdict();
  end
endmodule

// >>> tb/reset_receiver.sv
// Processor reset input model: measures each reset pulse it sees
`timescale 1ns/1ps
module reset_receiver (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Reset line from the supervisor
  input  wire logic         reset_out,
  // Measurement
  output logic              pulse_done,
  output logic [31:0]       pulse_len
);
  logic        last;
  logic        armed;
  logic [31:0] cnt;

  // ==========================================================================
  // Pulse measurement
  // Only pulses whose start was seen are reported, so power-on is skipped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last       <= 1'h0;
      armed      <= 1'h0;
      cnt        <= 32'h0;
      pulse_done <= 1'h0;
      pulse_len  <= 32'h0;
    end else begin
      last       <= reset_out;
      pulse_done <= 1'h0;
      if (last && !reset_out) begin
        armed <= 1'h1;
        cnt   <= 32'h1;
      end else if (!reset_out) begin
        cnt <= cnt + 32'h1;
      end else if (!last && armed) begin
        pulse_done <= 1'h1;
        pulse_len  <= cnt;
        armed      <= 1'h0;
      end
    end
  end
endmodule
